// >>> core/pwm_out_mux.sv
/*
 * output mux: turns the raw modulated signal into four pin values and
 * pin-ownership flags. assumes period_start_i is a one-cycle strobe from
 * the shared timebase and pwm_raw_i is synchronous to clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module pwm_out_mux (
   input  wire logic      clk_i,
   input  wire logic      sys_rst_i,
   input  wire logic      pwm_raw_i,
   input  wire logic      period_start_i,
   steer_cfg_if.mux       cfg,
   output logic [3:0]     pin_val_o,
   output logic [3:0]     pin_own_o,
   output logic           running_o
);
   logic       run_r;
   logic       phase_r;   // complementary toggle: 0 drives a, 1 drives b
   logic       act_hi;
   logic       act_lo;
   logic       pol_inv_ac;
   logic       pol_inv_bd;
   logic [3:0] own_nxt;
   logic [3:0] val_nxt;

   // wait for a fresh period after enable so the first pulse is whole
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !cfg.enable) begin
         run_r <= 1'b0;
      end else if (period_start_i) begin
         run_r <= 1'b1;
      end
   end

   // toggle the active output of the complementary pair every period
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || !cfg.complementary_assign) begin
         phase_r <= 1'b0;
      end else if (period_start_i && run_r) begin
         phase_r <= ~phase_r;
      end
   end

   // mode low bits pick active-low for a/c and b/d respectively
   assign pol_inv_ac = cfg.mode[pwm_steer_pkg::MODE_LO];
   assign pol_inv_bd = cfg.mode[pwm_steer_pkg::MODE_LO + 1];
   assign act_hi     = run_r & pwm_raw_i;
   assign act_lo     = 1'b0;

   // arrangement decode; unused pins are released to the port
   always_comb begin
      own_nxt = 4'h0;
      val_nxt = 4'h0;
      if (cfg.enable && cfg.mode[3:2] == pwm_steer_pkg::MODE_PWM_HI) begin
         case (pwm_steer_pkg::arrangement_t'(cfg.arrangement))
            pwm_steer_pkg::ARR_SINGLE: begin
               if (cfg.complementary_assign) begin
                  own_nxt = 4'h3;
                  val_nxt = {2'b00, act_hi & phase_r, act_hi & ~phase_r};
               end else begin
                  own_nxt = cfg.steer_en;
                  val_nxt = {4{act_hi}} & cfg.steer_en;
               end
            end
            pwm_steer_pkg::ARR_HALF: begin
               own_nxt = 4'h3;
               val_nxt = {2'b00, ~act_hi & run_r, act_hi};
            end
            pwm_steer_pkg::ARR_FULL_FWD: begin
               own_nxt = 4'hf;
               val_nxt = {act_hi, act_lo, act_lo, run_r};
            end
            pwm_steer_pkg::ARR_FULL_REV: begin
               own_nxt = 4'hf;
               val_nxt = {act_lo, run_r, act_hi, act_lo};
            end
            default: begin
               own_nxt = 4'h0;
               val_nxt = 4'h0;
            end
         endcase
      end else if (cfg.enable && cfg.mode[3:2] != 2'b00) begin
         // other nonzero mode upper bits: pin a only, arrangement and steering ignored
         own_nxt = 4'h1;
         val_nxt = {3'b000, act_hi};
      end
   end

   // registered pin values; polarity applied per pin pair
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pin_val_o <= 4'h0;
         pin_own_o <= 4'h0;
      end else begin
         pin_own_o <= own_nxt;
         pin_val_o <= val_nxt ^ ({pol_inv_bd, pol_inv_ac, pol_inv_bd, pol_inv_ac} & own_nxt);
      end
   end

   assign running_o = run_r;

   AST_NO_OUT_BEFORE_PERIOD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!run_r && !period_start_i) |=> ((pin_val_o & ~{pol_inv_bd, pol_inv_ac, pol_inv_bd, pol_inv_ac}
      & pin_own_o & 4'h1) == 4'h0 || !pin_own_o[0]))
      else $error("output before first period");
   AST_UNUSED_RELEASED: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!cfg.enable) |=> (pin_own_o == 4'h0))
      else $error("pin held while disabled");
   AST_COMPLEMENTARY_ASSIGN_TOGGLE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (cfg.complementary_assign && run_r && period_start_i && $stable(cfg.complementary_assign)) |=> (phase_r != $past(phase_r)))
      else $error("complementary phase did not toggle");
   AST_STEER_OWN: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (cfg.enable && cfg.mode[3:2] == 2'b11 && cfg.arrangement == 2'b00 && !cfg.complementary_assign)
      |=> (pin_own_o == $past(cfg.steer_en)))
      else $error("steering ownership mismatch");
endmodule
`default_nettype wire

// >>> core/pwm_steer_pkg.sv
/*
 * constants for the enhanced pwm output steering block: register map,
 * field positions, reset values and arrangement encodings.
 * assumes nothing of its surroundings.
 */
package pwm_steer_pkg;

   // register byte addresses on the 32-bit wishbone bus
   localparam logic [3:0] OFS_UNIT_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STEER_CTRL  = 4'h4;
   localparam logic [3:0] OFS_PIN_DIR     = 4'h8;
   localparam logic [3:0] OFS_STATUS      = 4'hc;

   // printed register indices, kept for reference by software
   localparam logic [11:0] IDX_STEER_CTRL_A = 12'hfbf;
   localparam logic [11:0] IDX_STEER_CTRL_B = 12'hfb9;

   // unit control register fields
   localparam int MODE_LO    = 0;   // unit_mode_field[3:0]
   localparam int MODE_W     = 4;
   localparam int ARR_LO     = 6;   // output_arrangement_sel[1:0]
   localparam int ARR_W      = 2;
   localparam int EN_BIT     = 8;   // pwm enable, own bit

   // steering control fields
   localparam int STR_LO     = 0;   // steer_en_a .. steer_en_d
   localparam int STR_W      = 4;
   localparam int SYNC_BIT   = 4;
   localparam int COMPLEMENTARY_ASSIGN_LO    = 6;
   localparam int COMPLEMENTARY_ASSIGN_W     = 2;

   localparam logic [7:0] UNIT_CTRL_RST  = 8'h00;
   localparam logic [7:0] STEER_CTRL_RST = 8'h01;
   localparam logic [7:0] STEER_WMASK    = 8'hdf;   // bit 5 reads zero
   localparam logic [3:0] PIN_DIR_RST    = 4'hf;

   localparam logic [1:0] MODE_PWM_HI    = 2'h3;    // mode upper bits for pwm
   localparam logic [1:0] COMPLEMENTARY_ASSIGN_ON        = 2'h1;
   localparam int         PWM_RES_BITS   = 10;

   typedef enum logic [1:0] {
      ARR_SINGLE   = 2'b00,
      ARR_FULL_FWD = 2'b01,
      ARR_HALF     = 2'b10,
      ARR_FULL_REV = 2'b11
   } arrangement_t;

endpackage

// >>> core/pwm_steer_top.sv
/*
 * enhanced pwm output steering: wishbone register file, steering update
 * timing and pin drive for four pwm outputs a..d.
 * assumes a shared timebase supplies pwm_raw_i and period_start_i, and that
 * the port logic drives pins whenever pin_own_o is low.
 */
//
// Contract
// - one waveform, 10-bit resolution, four pins
// - single, half, full forward, full reverse
// - arrangement chosen by selection field
// - pin polarity from unit mode field
// - first output waits for new period
// - unused pins released to other functions
// - complementary field toggles a/b per period
// - sync bit defers steering to period
// - sync clear applies steering immediately
// - steering bits d..a map outputs d..a
// - clear steering bit returns pin to port
`timescale 1ns/1ps
`default_nettype none
module pwm_steer_top (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   input  wire logic        pwm_raw_i,
   input  wire logic        period_start_i,
   input  wire logic [3:0]  port_val_i,
   output logic [3:0]       pwm_out_o,
   output logic [3:0]       pwm_out_oe_n_o,
   output logic [3:0]       pin_own_o
);
   steer_cfg_if cfg ();

   logic [8:0] unit_ctrl_r;
   logic [7:0] steer_ctrl_r;    // software image
   logic [3:0] steer_applied_r; // steering in force
   logic [1:0] complementary_assign_applied_r;
   logic       steer_pend_r;
   logic [3:0] pin_dir_r;       // 0 = output, like a direction latch
   logic [3:0] mux_val;
   logic [3:0] mux_own;
   logic       running;
   logic       req;
   logic       hit;
   logic [31:0] rd_nxt;

   // decode of a valid address, used for ack/err and to gate register writes
   function automatic logic addr_ok(input logic [3:0] a);
      addr_ok = (a == pwm_steer_pkg::OFS_UNIT_CTRL) || (a == pwm_steer_pkg::OFS_STEER_CTRL) ||
                (a == pwm_steer_pkg::OFS_PIN_DIR) || (a == pwm_steer_pkg::OFS_STATUS);
   endfunction

   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
   assign hit = addr_ok(wb_adr_i);

   // one-wait-state answer, dropped the cycle after it was given
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
      end else begin
         wb_ack_o <= req & hit;
         wb_err_o <= req & ~hit;
      end
   end

   // control registers; writes take effect at the ack edge
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         unit_ctrl_r  <= {1'b0, pwm_steer_pkg::UNIT_CTRL_RST};
         steer_ctrl_r <= pwm_steer_pkg::STEER_CTRL_RST;
         pin_dir_r    <= pwm_steer_pkg::PIN_DIR_RST;
      end else if (req && hit && wb_we_i) begin
         if (wb_adr_i == pwm_steer_pkg::OFS_UNIT_CTRL) begin
            if (wb_sel_i[0]) unit_ctrl_r[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) unit_ctrl_r[8]   <= wb_dat_i[pwm_steer_pkg::EN_BIT];
         end
         if (wb_adr_i == pwm_steer_pkg::OFS_STEER_CTRL && wb_sel_i[0]) begin
            steer_ctrl_r <= wb_dat_i[7:0] & pwm_steer_pkg::STEER_WMASK;
         end
         if (wb_adr_i == pwm_steer_pkg::OFS_PIN_DIR && wb_sel_i[0]) begin
            pin_dir_r <= wb_dat_i[3:0];
         end
      end
   end

   // steering update: immediate, or held to the next period start
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         steer_applied_r <= pwm_steer_pkg::STEER_CTRL_RST[3:0];
         complementary_assign_applied_r  <= 2'b00;
         steer_pend_r    <= 1'b0;
      end else if (!steer_ctrl_r[pwm_steer_pkg::SYNC_BIT]) begin
         steer_applied_r <= steer_ctrl_r[3:0];
         complementary_assign_applied_r  <= steer_ctrl_r[7:6];
         steer_pend_r    <= 1'b0;
      end else if (period_start_i) begin
         steer_applied_r <= steer_ctrl_r[3:0];
         complementary_assign_applied_r  <= steer_ctrl_r[7:6];
         steer_pend_r    <= 1'b0;
      end else if (steer_ctrl_r[3:0] != steer_applied_r || steer_ctrl_r[7:6] != complementary_assign_applied_r) begin
         steer_pend_r    <= 1'b1;
      end
   end

   assign cfg.mode        = unit_ctrl_r[3:0];
   assign cfg.arrangement = unit_ctrl_r[7:6];
   assign cfg.enable      = unit_ctrl_r[8];
   assign cfg.steer_en    = steer_applied_r;
   assign cfg.complementary_assign        = (complementary_assign_applied_r == pwm_steer_pkg::COMPLEMENTARY_ASSIGN_ON);

   pwm_out_mux u_mux (
      .clk_i          (clk_i),
      .sys_rst_i      (sys_rst_i),
      .pwm_raw_i      (pwm_raw_i),
      .period_start_i (period_start_i),
      .cfg            (cfg),
      .pin_val_o      (mux_val),
      .pin_own_o      (mux_own),
      .running_o      (running)
   );

   // pin drive: pwm value where owned, port value otherwise
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pwm_out_o      <= 4'h0;
         pwm_out_oe_n_o <= 4'hf;
      end else begin
         pwm_out_o      <= (mux_val & mux_own) | (port_val_i & ~mux_own);
         pwm_out_oe_n_o <= pin_dir_r;
      end
   end
   assign pin_own_o = mux_own;

   // read mux
   always_comb begin
      rd_nxt = 32'h0;
      case (wb_adr_i)
         pwm_steer_pkg::OFS_UNIT_CTRL:  rd_nxt = {23'h0, unit_ctrl_r};
         pwm_steer_pkg::OFS_STEER_CTRL: rd_nxt = {24'h0, steer_ctrl_r};
         pwm_steer_pkg::OFS_PIN_DIR:    rd_nxt = {28'h0, pin_dir_r};
         pwm_steer_pkg::OFS_STATUS:     rd_nxt = {22'h0, steer_pend_r, running, mux_own, steer_applied_r};
         default:                       rd_nxt = 32'h0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wb_dat_o <= 32'h0;
      end else if (req) begin
         wb_dat_o <= rd_nxt;
      end
   end

   AST_SYNC_HOLD: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (steer_ctrl_r[4] && !period_start_i && $stable(steer_ctrl_r)) |=> $stable(steer_applied_r))
      else $error("steering changed off period with sync set");
   AST_ASYNC_APPLY: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!steer_ctrl_r[4]) |=> (steer_applied_r == $past(steer_ctrl_r[3:0])))
      else $error("steering not applied at once");
   AST_PORT_PASS: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (mux_own == 4'h0) |=> (pwm_out_o == $past(port_val_i)))
      else $error("released pin not passed to port");
   AST_ACK_ONE: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
endmodule
`default_nettype wire

// >>> core/steer_cfg_if.sv
/*
 * interface carrying the live steering configuration from the register
 * file to the output mux. assumes both ends share clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
interface steer_cfg_if;
   logic [3:0] mode;        // unit_mode_field
   logic [1:0] arrangement; // output_arrangement_sel
   logic       enable;
   logic [3:0] steer_en;    // applied steering bits, d..a
   logic       complementary_assign;        // complementary toggling active
   modport regs (output mode, output arrangement, output enable, output steer_en, output complementary_assign);
   modport mux  (input mode, input arrangement, input enable, input steer_en, input complementary_assign);
endinterface
`default_nettype wire

// >>> verif/pin_load.sv
/*
 * load model for the four pwm pins: bridge gate inputs with pull-downs.
 * assumes oe_n low means the steering block drives the pin.
 */
`timescale 1ns/1ps
`default_nettype none
module pin_load (
   input  wire logic [3:0] drv_i,
   input  wire logic [3:0] oe_n_i,
   output logic      [3:0] pad_o
);
   // a released pin falls to the pull-down, never keeps the stale value
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pad_o[i] = oe_n_i[i] ? 1'b0 : drv_i[i];
      end
   end
endmodule
`default_nettype wire

// >>> verif/tb_enhanced_pwm_output_steering.sv
/*
 * self-checking bench for pwm_steer_top: register access, steering timing,
 * polarity, complementary toggling and output arrangements.
 * assumes a 50 MHz clock and the pin load model beside the block.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got_v, exp_v) begin checked++; if ((got_v) !== (exp_v)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got_v), (exp_v)); end end
module tb_enhanced_pwm_output_steering;
   logic        clk_i, sys_rst_i, cyc, stb, we, raw, ps, ack, err, bad;
   logic [3:0]  adr, sel, port_val, pwm, oe_n, own, pad, st;
   logic [1:0]  pv;
   logic [31:0] wdat, rdat, ex;
   logic [31:0] exp_q[$];
   int          errors, checked;
   logic [3:0]  t_own[4] = '{4'h1, 4'hf, 4'h3, 4'hf};
   logic [3:0]  t_hi[4]  = '{4'h1, 4'h9, 4'h1, 4'h6};
   logic [3:0]  t_lo[4]  = '{4'h0, 4'h1, 4'h2, 4'h4};

   pwm_steer_top u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wb_err_o(err), .pwm_raw_i(raw), .period_start_i(ps),
      .port_val_i(port_val), .pwm_out_o(pwm), .pwm_out_oe_n_o(oe_n), .pin_own_o(own));
   pin_load u_load (.drv_i(pwm), .oe_n_i(oe_n), .pad_o(pad));

   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   task automatic conclude();
      if (errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   // one classic wishbone cycle; the wait is bounded so a silent slave ends the run
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic e);
      int n;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (!(ack | err) && n < 20);
      if (n >= 20) begin
         errors++;
         conclude();
      end
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic e;
      bus(1'b1, a, d, e);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] x);
      logic e;
      exp_q.push_back(x);
      bus(1'b0, a, 32'h0, e);
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // one-cycle period strobe standing in for the shared timebase
   task automatic period();
      @(posedge clk_i);
      ps <= 1'b1;
      @(posedge clk_i);
      ps <= 1'b0;
   endtask

   task automatic unit(input logic [1:0] arr, input logic [3:0] mode);
      wr(pwm_steer_pkg::OFS_UNIT_CTRL, {23'h0, 1'b1, arr, 2'b00, mode});
   endtask

   // pins lag the raw level by two edges, so three give settled values
   task automatic pins(input logic r, input logic [3:0] o, input logic [3:0] v);
      @(posedge clk_i);
      raw <= r;
      tick(3);
      `CHK(own, o)
      `CHK(pwm & o, v & o)
   endtask

   // read answers are matched against the oldest expectation
   always @(posedge clk_i) begin
      if (ack && !we && exp_q.size() > 0) begin
         ex = exp_q.pop_front();
         `CHK(rdat, ex)
      end
   end

   initial begin
      {cyc, stb, we, raw, ps} = 5'h00;
      adr = 4'h0;
      sel = 4'hf;
      wdat = 32'h0;
      port_val = 4'h0;
      errors = 0;
      checked = 0;
      sys_rst_i = 1'b1;
      void'($urandom(26));
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      tick(1);
      `CHK(oe_n, pwm_steer_pkg::PIN_DIR_RST)
      `CHK(own, 4'h0)
      rd(pwm_steer_pkg::OFS_UNIT_CTRL, 32'h0);
      rd(pwm_steer_pkg::OFS_STEER_CTRL, {24'h0, pwm_steer_pkg::STEER_CTRL_RST});
      rd(pwm_steer_pkg::OFS_PIN_DIR, {28'h0, pwm_steer_pkg::PIN_DIR_RST});
      bus(1'b1, 4'h2, 32'hff, bad);
      `CHK(bad, 1'b1)
      wr(pwm_steer_pkg::OFS_STEER_CTRL, 32'hff);
      rd(pwm_steer_pkg::OFS_STEER_CTRL, {24'h0, pwm_steer_pkg::STEER_WMASK});
      wr(pwm_steer_pkg::OFS_PIN_DIR, 32'h0);
      tick(2);
      `CHK(oe_n, 4'h0)
      `CHK(pad, pwm)
      // nothing may leave the pins until a fresh period starts
      // the pins are claimed at once but stay idle while the raw level is high
      wr(pwm_steer_pkg::OFS_STEER_CTRL, 32'h0f);
      raw <= 1'b1;
      unit(2'b00, 4'hc);
      tick(3);
      `CHK(own, 4'hf)
      `CHK(pwm, 4'h0)
      period();
      pins(1'b1, 4'hf, 4'hf);
      // random steering applied at once with the sync bit clear
      for (int i = 0; i < 6; i++) begin
         st = 4'($urandom);
         port_val <= 4'($urandom);
         wr(pwm_steer_pkg::OFS_STEER_CTRL, {28'h0, st});
         pins(1'b1, st, st);
         `CHK(pwm & ~st, port_val & ~st)
         pins(1'b0, st, 4'h0);
      end
      // with sync set the change waits for the period strobe
      wr(pwm_steer_pkg::OFS_STEER_CTRL, 32'h05);
      wr(pwm_steer_pkg::OFS_STEER_CTRL, 32'h1a);
      tick(4);
      `CHK(own, 4'h5)
      period();
      pins(1'b1, 4'ha, 4'ha);
      wr(pwm_steer_pkg::OFS_STEER_CTRL, 32'h0f);
      for (int p = 0; p < 4; p++) begin
         unit(2'b00, {2'b11, 2'(p)});
         period();
         pins(1'b1, 4'hf, 4'hf ^ {2{2'(p)}});
      end
      // complementary mode swaps a and b every period
      unit(2'b00, 4'hc);
      wr(pwm_steer_pkg::OFS_STEER_CTRL, 32'h40);
      @(posedge clk_i);
      raw <= 1'b1;
      period();
      tick(3);
      pv = pwm[1:0];
      period();
      tick(3);
      `CHK(pwm[1:0] ^ pv, 2'b11)
      wr(pwm_steer_pkg::OFS_STEER_CTRL, 32'h0f);
      for (int k = 0; k < 4; k++) begin
         unit(2'(k), (k == 0) ? 4'h8 : 4'hc);
         period();
         pins(1'b1, t_own[k], t_hi[k]);
         pins(1'b0, t_own[k], t_lo[k]);
      end
      conclude();
   end
endmodule
`default_nettype wire
